// ### pkg/cfg_loader_cfg.svh
`ifndef CFG_LOADER_CFG_SVH
`define CFG_LOADER_CFG_SVH
// Operation
// RULE_01 - configuration file first, then coding switch, then user program start.
// RULE_02 - assignment lines applied strictly in file order; later writes win.
// RULE_03 - a line starting with a semicolon is a comment and is skipped.
// RULE_04 - index is exactly four hex digits followed by a colon.
// RULE_05 - subindex is two hex digits; may be omitted with its colon, meaning zero.
// RULE_06 - hex values carry a 0x prefix and are converted before writing.
// RULE_07 - supports bit set/clear by dot bit number, and OR / AND with a mask.
// RULE_08 - file writer puts no blanks around the assignment operator.
// RULE_09 - lines start directly with index digits; no leading blanks or short fields.
// RULE_10 - values are written without any check of their meaning.
// RULE_11 - a missing configuration file is created empty at startup.
// RULE_12 - at power-on every file other than the four kept ones is deleted.
// RULE_13 - an empty restart file restarts the device; it is deleted on restart.
// RULE_14 - user program autostarts only when program-run object equals one.
// RULE_15 - a missing user program image is created empty under its fixed name.
// RULE_16 - user program recognised only under its single fixed image name.
// RULE_17 - the volume shows configuration file, program image and information file.
// RULE_18 - saving a modified configuration file stops the motor; values apply on restart.
// RULE_19 - operator removes supply about one second before reconnecting.
// RULE_20 - an unrecognised line is skipped without writing and parsing continues.
// RULE_21 - values without the hex prefix are read as decimal.

`define CH_SEMI 8'h3b
`define CH_COLON 8'h3a
`define CH_EQ 8'h3d
`define CH_DOT 8'h2e
`define CH_OR 8'h7c
`define CH_AND 8'h26
`define CH_LF 8'h0a
`define CH_CR 8'h0d
`define CH_ZERO 8'h30
`define CH_XLOW 8'h78
`define RUN_INDEX 16'h2300
`define RUN_SUBINDEX 8'h00
`define RUN_VALUE 32'h0000_0001
`endif

// ### pkg/cfg_loader_pkg.sv
package cfg_loader_pkg;
  typedef enum logic [2:0]
  {
    WR_WHOLE = 3'h0,
    WR_BITSET = 3'h1,
    WR_BITCLR = 3'h2,
    WR_OR = 3'h3,
    WR_AND = 3'h4
  } wr_op_t;

  typedef enum logic [3:0]
  {
    PS_IDX = 4'h0,
    PS_AFTIDX = 4'h1,
    PS_SUB = 4'h2,
    PS_AFTSUB = 4'h3,
    PS_BIT = 4'h4,
    PS_OPEQ = 4'h5,
    PS_VAL0 = 4'h6,
    PS_VALX = 4'h7,
    PS_VAL = 4'h8,
    PS_SKIP = 4'h9
  } parse_t;

  typedef enum logic [2:0]
  {
    SQ_FILES = 3'h0,
    SQ_PARSE = 3'h1,
    SQ_SWITCH = 3'h2,
    SQ_START = 3'h3,
    SQ_RUN = 3'h4
  } seq_t;
endpackage

// ### design/cfg_line_parser.sv
`timescale 1ns/1ps
`include "cfg_loader_cfg.svh"
module cfg_line_parser
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic chValid,
  input wire logic [7:0] chData,
  output logic chReady,
  output logic objWrite,
  output logic [15:0] objIndex,
  output logic [7:0] objSubindex,
  output logic [31:0] objValue,
  output cfg_loader_pkg::wr_op_t objOp,
  output logic [4:0] objBit,
  output logic lineDone
);
  function automatic logic isHex(input logic [7:0] c);
    isHex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
      (c >= 8'h61 && c <= 8'h66);
  endfunction

  function automatic logic [3:0] hexVal(input logic [7:0] c);
    if (c <= 8'h39)
      hexVal = c[3:0];
    else
      hexVal = c[3:0] + 4'h9;
  endfunction

  function automatic logic isDec(input logic [7:0] c);
    isDec = c >= 8'h30 && c <= 8'h39;
  endfunction

  cfg_loader_pkg::parse_t state_q, state_d;
  logic [2:0] cnt_q;
  logic [15:0] idx_q;
  logic [7:0] sub_q;
  logic [31:0] val_q;
  logic [4:0] bit_q;
  logic hexMode_q;
  logic bitSel_q;
  cfg_loader_pkg::wr_op_t op_q;

  wire logic isEol = chData == `CH_LF || chData == `CH_CR;
  wire logic take = chValid;
  wire logic chHex = isHex(chData);
  wire logic chDec = isDec(chData);
  wire logic [31:0] decNext = (val_q << 3) + (val_q << 1) + {28'h0, chData[3:0]};
  wire logic [31:0] hexNext = {val_q[27:0], hexVal(chData)};
  // a value line commits only at end of line, so garbage later in the line drops it
  wire logic commit = take && isEol &&
    (state_q == cfg_loader_pkg::PS_VAL || state_q == cfg_loader_pkg::PS_VALX);
  wire logic [4:0] bitNext = 5'(bit_q * 5'h10 + {1'b0, hexVal(chData)});

  assign chReady = 1'b1;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      cfg_loader_pkg::PS_IDX:
        if (cnt_q == 3'h0 && chData == `CH_SEMI)
          state_d = cfg_loader_pkg::PS_SKIP; // RULE_03
        else if (!chHex)
          state_d = cfg_loader_pkg::PS_SKIP; // RULE_09
        else if (cnt_q == 3'h3)
          state_d = cfg_loader_pkg::PS_AFTIDX; // RULE_04
      cfg_loader_pkg::PS_AFTIDX:
        if (chData == `CH_COLON)
          state_d = cfg_loader_pkg::PS_SUB;
        else
          state_d = cfg_loader_pkg::PS_SKIP; // RULE_04
      cfg_loader_pkg::PS_SUB:
        if (!chHex)
          state_d = cfg_loader_pkg::PS_SKIP;
        else if (cnt_q == 3'h1)
          state_d = cfg_loader_pkg::PS_AFTSUB; // RULE_05
      cfg_loader_pkg::PS_AFTSUB, cfg_loader_pkg::PS_BIT:
        if (chData == `CH_EQ)
          state_d = cfg_loader_pkg::PS_VAL0;
        else if (chData == `CH_DOT && state_q == cfg_loader_pkg::PS_AFTSUB)
          state_d = cfg_loader_pkg::PS_BIT; // RULE_07
        else if ((chData == `CH_OR || chData == `CH_AND) && state_q == cfg_loader_pkg::PS_AFTSUB)
          state_d = cfg_loader_pkg::PS_OPEQ; // RULE_07
        else if (!(state_q == cfg_loader_pkg::PS_BIT && chHex))
          state_d = cfg_loader_pkg::PS_SKIP; // RULE_08
      cfg_loader_pkg::PS_OPEQ:
        state_d = chData == `CH_EQ ? cfg_loader_pkg::PS_VAL0 : cfg_loader_pkg::PS_SKIP;
      cfg_loader_pkg::PS_VAL0:
        if (chData == `CH_ZERO)
          state_d = cfg_loader_pkg::PS_VALX;
        else if (chDec)
          state_d = cfg_loader_pkg::PS_VAL; // RULE_21
        else
          state_d = cfg_loader_pkg::PS_SKIP; // RULE_08
      cfg_loader_pkg::PS_VALX:
        if (chData == `CH_XLOW)
          state_d = cfg_loader_pkg::PS_VAL; // RULE_06
        else if (chDec)
          state_d = cfg_loader_pkg::PS_VAL;
        else
          state_d = cfg_loader_pkg::PS_SKIP;
      cfg_loader_pkg::PS_VAL:
        if (!(hexMode_q ? chHex : chDec))
          state_d = cfg_loader_pkg::PS_SKIP; // RULE_20
      cfg_loader_pkg::PS_SKIP:
        state_d = cfg_loader_pkg::PS_SKIP;
      default:
        state_d = cfg_loader_pkg::PS_SKIP;
    endcase
    if (isEol)
      state_d = cfg_loader_pkg::PS_IDX;
    // omitted subindex: colon missing means "=" right after index
    if (state_q == cfg_loader_pkg::PS_AFTIDX && chData == `CH_EQ)
      state_d = cfg_loader_pkg::PS_VAL0; // RULE_05
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= cfg_loader_pkg::PS_IDX;
      cnt_q <= 3'h0;
      idx_q <= 16'h0;
      sub_q <= 8'h0;
      val_q <= 32'h0;
      bit_q <= 5'h0;
      hexMode_q <= 1'b0;
      bitSel_q <= 1'b0;
      op_q <= cfg_loader_pkg::WR_WHOLE;
    end
    else if (take)
    begin
      state_q <= state_d;
      // restart the count on every line end, or a CR LF pair eats an index digit
      cnt_q <= (state_d != state_q || isEol) ? 3'h0 : cnt_q + 3'h1;
      if (state_q == cfg_loader_pkg::PS_IDX)
      begin
        idx_q <= {idx_q[11:0], hexVal(chData)};
        sub_q <= 8'h0;
        val_q <= 32'h0;
        bit_q <= 5'h0;
        hexMode_q <= 1'b0;
        bitSel_q <= 1'b0;
        op_q <= cfg_loader_pkg::WR_WHOLE;
      end
      if (state_q == cfg_loader_pkg::PS_SUB)
        sub_q <= {sub_q[3:0], hexVal(chData)};
      if (state_q == cfg_loader_pkg::PS_AFTSUB && chData == `CH_DOT)
        bitSel_q <= 1'b1;
      if (state_q == cfg_loader_pkg::PS_BIT && chHex)
        bit_q <= bitNext;
      if (state_q == cfg_loader_pkg::PS_AFTSUB && chData == `CH_OR)
        op_q <= cfg_loader_pkg::WR_OR;
      if (state_q == cfg_loader_pkg::PS_AFTSUB && chData == `CH_AND)
        op_q <= cfg_loader_pkg::WR_AND;
      if (state_q == cfg_loader_pkg::PS_VALX && chData == `CH_XLOW)
        hexMode_q <= 1'b1;
      if ((state_q == cfg_loader_pkg::PS_VAL0 || state_q == cfg_loader_pkg::PS_VALX) && chDec)
        val_q <= {28'h0, chData[3:0]};
      if (state_q == cfg_loader_pkg::PS_VAL)
        val_q <= hexMode_q ? hexNext : decNext; // RULE_06 RULE_21
    end
  end

  // no range or type checks on the value
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      objWrite <= 1'b0;
      objIndex <= 16'h0;
      objSubindex <= 8'h0;
      objValue <= 32'h0;
      objOp <= cfg_loader_pkg::WR_WHOLE;
      objBit <= 5'h0;
      lineDone <= 1'b0;
    end
    else
    begin
      objWrite <= commit; // RULE_10
      lineDone <= take && isEol;
      if (commit)
      begin
        objIndex <= idx_q;
        objSubindex <= sub_q;
        objValue <= val_q;
        objBit <= bit_q;
        if (bitSel_q)
          objOp <= val_q[0] ? cfg_loader_pkg::WR_BITSET : cfg_loader_pkg::WR_BITCLR; // RULE_07
        else
          objOp <= op_q;
      end
    end
  end

  AST_NO_WRITE_ON_COMMENT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_q == cfg_loader_pkg::PS_SKIP && !(chValid && isEol) |=> !objWrite) // RULE_03
    else $error("write issued from a skipped line");
  AST_WRITE_AFTER_EOL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    objWrite |-> $past(chValid && isEol)) // RULE_20
    else $error("write not tied to end of line");
endmodule

// ### design/startup_config_file_loader.sv
`timescale 1ns/1ps
`include "cfg_loader_cfg.svh"
module startup_config_file_loader
(
  input wire logic ref_clk,
  input wire logic reset_n,
  // storage volume status at startup
  input wire logic cfgPresent,
  input wire logic progPresent,
  input wire logic restartFilePresent,
  input wire logic strayFilePresent,
  input wire logic volumeOpDone,
  // configuration file byte stream
  input wire logic cfgByteValid,
  input wire logic [7:0] cfgByte,
  input wire logic cfgEof,
  output logic cfgByteReady,
  // object dictionary access
  output logic odWrite,
  output logic [15:0] odIndex,
  output logic [7:0] odSubindex,
  output logic [31:0] odWriteValue,
  output logic odRead,
  input wire logic [31:0] odReadValue,
  // file housekeeping requests
  output logic createCfg,
  output logic createProg,
  output logic deleteStray,
  output logic deleteRestartFile,
  output logic restartRequest,
  // host activity
  input wire logic hostCfgSaved,
  input wire logic hostRestartFileWritten,
  output logic motorStop,
  output logic massStorageEnable,
  // special drive mode switch and program
  input wire logic [3:0] modeSwitch,
  output logic [3:0] driveMode,
  output logic driveModeValid,
  output logic progStart,
  output logic startupDone
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] swMeta_q, swSync_q;
  logic [1:0] savedSync_q, rstSync_q;
  logic savedPrev_q, rstPrev_q;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      swMeta_q <= 4'h0;
      swSync_q <= 4'h0;
      savedSync_q <= 2'h0;
      rstSync_q <= 2'h0;
      savedPrev_q <= 1'b0;
      rstPrev_q <= 1'b0;
    end
    else
    begin
      swMeta_q <= modeSwitch;
      swSync_q <= swMeta_q;
      savedSync_q <= {savedSync_q[0], hostCfgSaved};
      rstSync_q <= {rstSync_q[0], hostRestartFileWritten};
      savedPrev_q <= savedSync_q[1];
      rstPrev_q <= rstSync_q[1];
    end
  end

  wire logic savedEdge = savedSync_q[1] && !savedPrev_q;
  wire logic restartEdge = rstSync_q[1] && !rstPrev_q;

  // ---------------------------------------------------------------
  // line parser
  // ---------------------------------------------------------------
  cfg_loader_pkg::seq_t seq_q, seq_d;
  logic rmwBusy_q;
  logic pWrite;
  logic [15:0] pIndex;
  logic [7:0] pSub;
  logic [31:0] pValue;
  cfg_loader_pkg::wr_op_t pOp;
  logic [4:0] pBit;
  logic pReady;
  wire logic parsing = seq_q == cfg_loader_pkg::SQ_PARSE;
  // bytes taken one after another keep file order
  wire logic feed = parsing && cfgByteValid && !rmwBusy_q;

  cfg_line_parser u_parser
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .chValid(feed), // RULE_02
    .chData(cfgByte),
    .chReady(pReady),
    .objWrite(pWrite),
    .objIndex(pIndex),
    .objSubindex(pSub),
    .objValue(pValue),
    .objOp(pOp),
    .objBit(pBit),
    .lineDone()
  );

  assign cfgByteReady = parsing && pReady && !rmwBusy_q;

  // ---------------------------------------------------------------
  // object writes with read-modify-write
  // ---------------------------------------------------------------
  // modify ops need the current value; one stall cycle per such line
  logic [15:0] wIdx_q;
  logic [7:0] wSub_q;
  logic [31:0] wVal_q;
  logic [4:0] wBit_q;
  cfg_loader_pkg::wr_op_t wOp_q;
  logic runObj_q;
  logic wholeWrite;

  assign wholeWrite = pWrite && pOp == cfg_loader_pkg::WR_WHOLE;

  wire logic [31:0] bitMask = 32'h1 << wBit_q;
  wire logic [31:0] modVal =
    wOp_q == cfg_loader_pkg::WR_OR ? (odReadValue | wVal_q) :
    wOp_q == cfg_loader_pkg::WR_AND ? (odReadValue & wVal_q) :
    wOp_q == cfg_loader_pkg::WR_BITSET ? (odReadValue | bitMask) :
    (odReadValue & ~bitMask);

  wire logic isRunObj = odIndex == `RUN_INDEX && odSubindex == `RUN_SUBINDEX;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rmwBusy_q <= 1'b0;
      wIdx_q <= 16'h0;
      wSub_q <= 8'h0;
      wVal_q <= 32'h0;
      wBit_q <= 5'h0;
      wOp_q <= cfg_loader_pkg::WR_WHOLE;
    end
    else
    begin
      if (pWrite && !wholeWrite)
      begin
        rmwBusy_q <= 1'b1; // RULE_07
        wIdx_q <= pIndex;
        wSub_q <= pSub;
        wVal_q <= pValue;
        wBit_q <= pBit;
        wOp_q <= pOp;
      end
      else
        rmwBusy_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      odWrite <= 1'b0;
      odIndex <= 16'h0;
      odSubindex <= 8'h0;
      odWriteValue <= 32'h0;
    end
    else
    begin
      odWrite <= wholeWrite || rmwBusy_q;
      if (wholeWrite)
      begin
        odIndex <= pIndex;
        odSubindex <= pSub;
        odWriteValue <= pValue; // RULE_10
      end
      else if (rmwBusy_q)
      begin
        odIndex <= wIdx_q;
        odSubindex <= wSub_q;
        odWriteValue <= modVal;
      end
      else if (pWrite)
      begin
        // the read in the stall cycle must address the modified object
        odIndex <= pIndex;
        odSubindex <= pSub;
      end
    end
  end

  assign odRead = rmwBusy_q;

  // last write to the run object wins
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      runObj_q <= 1'b0;
    else if (odWrite && isRunObj)
      runObj_q <= odWriteValue == `RUN_VALUE; // RULE_14
  end

  // ---------------------------------------------------------------
  // startup sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    seq_d = seq_q;
    unique case (seq_q)
      cfg_loader_pkg::SQ_FILES:
        if (volumeOpDone)
          seq_d = cfg_loader_pkg::SQ_PARSE;
      cfg_loader_pkg::SQ_PARSE:
        // trailing writes drain before the switch is read
        if (cfgEof && !cfgByteValid && !rmwBusy_q && !pWrite && !odWrite)
          seq_d = cfg_loader_pkg::SQ_SWITCH; // RULE_01
      cfg_loader_pkg::SQ_SWITCH:
        seq_d = cfg_loader_pkg::SQ_START; // RULE_01
      cfg_loader_pkg::SQ_START:
        seq_d = cfg_loader_pkg::SQ_RUN;
      cfg_loader_pkg::SQ_RUN:
        seq_d = cfg_loader_pkg::SQ_RUN;
      default:
        seq_d = cfg_loader_pkg::SQ_FILES;
    endcase
  end

  logic filesReq_q;
  logic filesDone_q;
  logic motorStop_q;
  logic restartReq_q;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seq_q <= cfg_loader_pkg::SQ_FILES;
      filesReq_q <= 1'b0;
      filesDone_q <= 1'b0;
      driveMode <= 4'h0;
      driveModeValid <= 1'b0;
      progStart <= 1'b0;
      motorStop_q <= 1'b0;
      restartReq_q <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      filesDone_q <= 1'b1;
      filesReq_q <= !filesDone_q;
      progStart <= seq_q == cfg_loader_pkg::SQ_START && runObj_q; // RULE_14
      if (seq_q == cfg_loader_pkg::SQ_SWITCH)
      begin
        driveMode <= swSync_q;
        driveModeValid <= 1'b1;
      end
      if (savedEdge)
        motorStop_q <= 1'b1; // RULE_18
      if (restartEdge)
        restartReq_q <= 1'b1; // RULE_13
    end
  end

  // housekeeping pulses issued once, one cycle after reset release
  assign createCfg = filesReq_q && !cfgPresent; // RULE_11
  assign createProg = filesReq_q && !progPresent; // RULE_15 RULE_16
  assign deleteStray = filesReq_q && strayFilePresent; // RULE_12
  assign deleteRestartFile = filesReq_q && restartFilePresent; // RULE_13
  assign restartRequest = restartReq_q;
  assign motorStop = motorStop_q;
  assign massStorageEnable = seq_q != cfg_loader_pkg::SQ_FILES; // RULE_17
  assign startupDone = seq_q == cfg_loader_pkg::SQ_RUN;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_SWITCH_AFTER_FILE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(driveModeValid) |-> $past(seq_q) == cfg_loader_pkg::SQ_SWITCH) // RULE_01
    else $error("switch read outside its step");
  AST_START_AFTER_SWITCH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    progStart |-> driveModeValid) // RULE_01
    else $error("program started before switch read");
  AST_START_NEEDS_RUN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    progStart |-> $past(runObj_q)) // RULE_14
    else $error("program started without run object");
  AST_NO_WRITE_AFTER_PARSE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    seq_q == cfg_loader_pkg::SQ_RUN |-> !odWrite) // RULE_02
    else $error("object write after parse");
  AST_RMW_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rmwBusy_q |=> odWrite && odWriteValue == $past(modVal)) // RULE_07
    else $error("modify write wrong");
  AST_STOP_ON_SAVE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    savedEdge |=> motorStop) // RULE_18
    else $error("motor not stopped on save");
  AST_RESTART: assert property (@(posedge ref_clk) disable iff (!reset_n)
    restartEdge |=> restartRequest) // RULE_13
    else $error("restart not requested");
  AST_CREATE_CFG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(filesReq_q) |-> $past(createCfg) == !$past(cfgPresent)) // RULE_11
    else $error("config file creation wrong");
endmodule

// ### verif/volume_model.sv
`timescale 1ns/1ps
module volume_model
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cfgByteReady,
  input wire logic odWrite,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSubindex,
  input wire logic [31:0] odWriteValue,
  input wire logic odRead,
  output logic cfgByteValid,
  output logic [7:0] cfgByte,
  output logic cfgEof,
  output logic volumeOpDone,
  output logic [31:0] odReadValue
);
  // ----------------------------------------
  // file stream and object store
  // ----------------------------------------
  string text = "";
  int pos;
  int settle;
  logic taken;
  logic [31:0] mem [logic [23:0]];
  logic [55:0] writeLog [$];
  logic [23:0] key;
  assign key = {odIndex, odSubindex};
  // outside a read the value flips, so a stale sample never matches
  always_comb odReadValue = odRead ? (mem.exists(key) ? mem[key] : 32'h0) : ~odWriteValue;
  always @(posedge ref_clk)
  begin
    taken = cfgByteValid && cfgByteReady;
    if (odWrite === 1'b1)
    begin
      mem[key] = odWriteValue;
      writeLog.push_back({key, odWriteValue});
    end
  end
  // bytes leave whole, in file order, only once housekeeping is over
  always @(negedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pos = 0;
      settle = 0;
      taken = 1'b0;
      cfgByteValid <= 1'b0;
      cfgEof <= 1'b0;
      volumeOpDone <= 1'b0;
      cfgByte <= 8'h00;
    end
    else
    begin
      if (taken)
        pos++;
      taken = 1'b0;
      if (settle < 3)
        settle++;
      volumeOpDone <= settle >= 3;
      cfgByteValid <= settle >= 3 && pos < text.len();
      cfgByte <= (settle >= 3 && pos < text.len()) ? text[pos] : ~cfgByte;
      cfgEof <= settle >= 3 && pos >= text.len();
    end
  end
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cfgPresent = 1'b1, progPresent = 1'b1, restartFilePresent = 1'b0, strayFilePresent = 1'b0;
  logic hostCfgSaved = 1'b0, hostRestartFileWritten = 1'b0;
  logic [3:0] modeSwitch = 4'h0;
  logic volumeOpDone, cfgByteValid, cfgEof, cfgByteReady, odWrite, odRead;
  logic [7:0] cfgByte, odSubindex;
  logic [15:0] odIndex;
  logic [31:0] odWriteValue, odReadValue;
  logic createCfg, createProg, deleteStray, deleteRestartFile, restartRequest;
  logic motorStop, massStorageEnable, driveModeValid, progStart, startupDone;
  logic [3:0] driveMode;
  logic sawCfg, sawProg, sawStray, sawRst;
  int starts;
  time tWrite, tMode, tStart;
  int fails = 0;
  int comparisons = 0;

  startup_config_file_loader startup_config_file_loader_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .cfgPresent(cfgPresent), .progPresent(progPresent), .restartFilePresent(restartFilePresent),
    .strayFilePresent(strayFilePresent), .volumeOpDone(volumeOpDone), .cfgByteValid(cfgByteValid),
    .cfgByte(cfgByte), .cfgEof(cfgEof), .cfgByteReady(cfgByteReady), .odWrite(odWrite),
    .odIndex(odIndex), .odSubindex(odSubindex), .odWriteValue(odWriteValue), .odRead(odRead),
    .odReadValue(odReadValue), .createCfg(createCfg), .createProg(createProg),
    .deleteStray(deleteStray), .deleteRestartFile(deleteRestartFile),
    .restartRequest(restartRequest), .hostCfgSaved(hostCfgSaved),
    .hostRestartFileWritten(hostRestartFileWritten), .motorStop(motorStop),
    .massStorageEnable(massStorageEnable), .modeSwitch(modeSwitch), .driveMode(driveMode),
    .driveModeValid(driveModeValid), .progStart(progStart), .startupDone(startupDone));
  volume_model volume_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .cfgByteReady(cfgByteReady),
    .odWrite(odWrite), .odIndex(odIndex), .odSubindex(odSubindex), .odWriteValue(odWriteValue),
    .odRead(odRead), .cfgByteValid(cfgByteValid), .cfgByte(cfgByte), .cfgEof(cfgEof),
    .volumeOpDone(volumeOpDone), .odReadValue(odReadValue));

  // ----------------------------------------
  // clock, monitors, helpers
  // ----------------------------------------
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (createCfg === 1'b1) sawCfg = 1'b1;
    if (createProg === 1'b1) sawProg = 1'b1;
    if (deleteStray === 1'b1) sawStray = 1'b1;
    if (deleteRestartFile === 1'b1) sawRst = 1'b1;
    if (progStart === 1'b1)
    begin
      starts++;
      tStart = $time;
    end
    if (odWrite === 1'b1) tWrite = $time;
    if (driveModeValid === 1'b1 && tMode == 0) tMode = $time;
  end
  task check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  function automatic logic [55:0] e(input logic [15:0] i, input logic [7:0] s, input logic [31:0] v);
    return {i, s, v};
  endfunction
  task checkLog(input logic [55:0] exp [$]);
    check(volume_model_i.writeLog.size() == exp.size(), "object write count");
    foreach (exp[i])
      if (i < volume_model_i.writeLog.size())
        check(volume_model_i.writeLog[i] === exp[i], "object write content");
  endtask
  // supply held off ten cycles before each start
  task boot(input string txt, input logic [3:0] vol);
    int n;
    @(negedge ref_clk);
    reset_n = 1'b0;
    {cfgPresent, progPresent, restartFilePresent, strayFilePresent} = vol;
    volume_model_i.text = vol[3] ? txt : "";
    volume_model_i.mem.delete();
    volume_model_i.writeLog.delete();
    {sawCfg, sawProg, sawStray, sawRst} = 4'h0;
    starts = 0;
    tMode = 0;
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    for (n = 0; n < 2000 && startupDone !== 1'b1; n++) @(negedge ref_clk);
    check(startupDone === 1'b1, "startup never finished");
    repeat (3) @(negedge ref_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task scen_files;
    boot("", 4'b0011);
    check({sawCfg, sawProg, sawStray, sawRst} === 4'hf, "housekeeping pulses");
    check(starts == 0, "program started without run object");
    check(massStorageEnable === 1'b1, "volume not shown");
  endtask
  task scen_start;
    modeSwitch = 4'h9;
    boot("2300:00=1\n", 4'b1100);
    check({sawCfg, sawProg, sawStray, sawRst} === 4'h0, "needless housekeeping");
    checkLog('{e(16'h2300, 8'h00, 32'h1)});
    check(starts == 1, "program start count");
    check(driveMode === 4'h9 && driveModeValid === 1'b1, "drive mode");
    check(tWrite < tMode && tMode <= tStart, "startup order");
    modeSwitch = 4'h0;
  endtask
  task scen_syntax;
    boot({"203B:01=600\n;2300:00=1\n6040:00 = 5\n6040:00= 5\n 6040:00=6\n6040:0=6\n",
          "6040=6\n1234=0x1f\n203b:01=0x10\015\n2300:00=1\n2300:00=0\n"}, 4'b1100);
    checkLog('{e(16'h203b, 8'h01, 32'h258), e(16'h6040, 8'h00, 32'h6),
               e(16'h1234, 8'h00, 32'h1f), e(16'h203b, 8'h01, 32'h10),
               e(16'h2300, 8'h00, 32'h1),
               e(16'h2300, 8'h00, 32'h0)});
    check(starts == 0, "last run write was zero");
  endtask
  task scen_modify;
    boot("3202:00=5\n3202:00|=0x0a\n3202:00&=0x0c\n3202:00.02=0\n3202:00.04=1\n", 4'b1100);
    checkLog('{e(16'h3202, 8'h00, 32'h5), e(16'h3202, 8'h00, 32'hf), e(16'h3202, 8'h00, 32'hc),
               e(16'h3202, 8'h00, 32'h8), e(16'h3202, 8'h00, 32'h18)});
  endtask
  task scen_host;
    check(motorStop === 1'b0 && restartRequest === 1'b0, "idle host flags");
    hostCfgSaved = 1'b1;
    repeat (3) @(negedge ref_clk);
    hostCfgSaved = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(motorStop === 1'b1, "motor not stopped on save");
    check(restartRequest === 1'b0, "restart without trigger file");
    hostRestartFileWritten = 1'b1;
    repeat (3) @(negedge ref_clk);
    hostRestartFileWritten = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(restartRequest === 1'b1, "no restart on trigger file");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task close_out;
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    fails++;
    close_out();
  end
  initial
  begin
    scen_files();
    scen_start();
    scen_syntax();
    scen_modify();
    scen_host();
    close_out();
  end
endmodule
